// File: hdl/lart_gap_timer.sv
// Purpose: gap timer that holds off new l1 entry requests after a reject
// Assumes: link-layer events arrive as one-cycle pulses synchronous to mclk
// Notes:   one gap unit counts one mclk cycle
`timescale 1ns/1ps
module lart_gap_timer
    import lart_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // link layer events
    input  wire logic        req_dllp_rx,
    input  wire logic        ack_tx,
    input  wire logic        nak_tx,
    // status toward the link layer
    output logic             new_request,
    output logic             request_open,
    output logic             gap_active
);
    logic [13:0]  min_entry_request_gap;
    logic         gap_timer_start_select;
    logic [13:0]  gap_cnt;
    lart_state_e  state;
    logic         hit;

    assign hit = (reg_addr == LART_CTRL_OFS);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            min_entry_request_gap  <= LART_GAP_RST;
            gap_timer_start_select <= LART_START_SEL_RST;
        end else if (reg_wr && hit) begin
            min_entry_request_gap  <= reg_wdata[LART_GAP_LSB +: LART_GAP_W];
            gap_timer_start_select <= reg_wdata[LART_START_SEL_BIT];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd && hit) begin
            reg_rdata <= 32'h0;
            reg_rdata[LART_GAP_LSB +: LART_GAP_W] <= min_entry_request_gap;
            reg_rdata[LART_START_SEL_BIT] <= gap_timer_start_select;
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // readback mirrors the fields exactly as the timer uses them
    property p_read_gap;
        @(posedge mclk) disable iff (rst)
        reg_rd && hit
            |=> reg_rdata[LART_GAP_LSB +: LART_GAP_W] == $past(min_entry_request_gap);
    endproperty
    a_read_gap: assert property (p_read_gap) else $error("gap field read wrong");

    property p_read_sel;
        @(posedge mclk) disable iff (rst)
        reg_rd && hit
            |=> reg_rdata[LART_START_SEL_BIT] == $past(gap_timer_start_select);
    endproperty
    a_read_sel: assert property (p_read_sel) else $error("select bit read wrong");

    property p_write_gap;
        @(posedge mclk) disable iff (rst)
        reg_wr && hit
            |=> min_entry_request_gap == $past(reg_wdata[LART_GAP_LSB +: LART_GAP_W]);
    endproperty
    a_write_gap: assert property (p_write_gap) else $error("gap field not written");

    property p_write_sel;
        @(posedge mclk) disable iff (rst)
        reg_wr && hit
            |=> gap_timer_start_select == $past(reg_wdata[LART_START_SEL_BIT]);
    endproperty
    a_write_sel: assert property (p_write_sel) else $error("select bit not written");

    // a stray write elsewhere in the space must not disturb the timer setup
    property p_unmapped_wr;
        @(posedge mclk) disable iff (rst)
        reg_wr && !hit
            |=> $stable(min_entry_request_gap) && $stable(gap_timer_start_select);
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

    property p_rdata_idle;
        @(posedge mclk) disable iff (rst)
        !$past(reg_rd && hit) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

    // a gap of zero means no hold-off at all
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state   <= LART_IDLE;
            gap_cnt <= 14'h0;
        end else begin
            unique case (state)
                LART_IDLE: begin
                    if (req_dllp_rx) begin
                        state <= LART_REQ;
                    end
                end
                LART_REQ: begin
                    if (nak_tx && min_entry_request_gap != 14'h0) begin
                        state   <= LART_GAP;
                        gap_cnt <= min_entry_request_gap;
                    end else if (nak_tx || ack_tx) begin
                        state <= LART_IDLE;
                    end
                end
                LART_GAP: begin
                    if (req_dllp_rx && !gap_timer_start_select) begin
                        gap_cnt <= min_entry_request_gap;
                    end else if (gap_cnt == 14'h1) begin
                        state   <= LART_IDLE;
                        gap_cnt <= 14'h0;
                    end else begin
                        gap_cnt <= gap_cnt - 14'h1;
                    end
                end
                default: state <= LART_IDLE;
            endcase
        end
    end

    assign new_request  = (state == LART_IDLE) && req_dllp_rx;
    assign request_open = (state == LART_REQ);
    assign gap_active   = (state == LART_GAP);

    property p_gap_blocks;
        @(posedge mclk) disable iff (rst)
        gap_active && req_dllp_rx |=> !request_open;
    endproperty
    a_gap_blocks: assert property (p_gap_blocks) else $error("request seen in gap");

    property p_nak_starts;
        @(posedge mclk) disable iff (rst)
        request_open && nak_tx && min_entry_request_gap != 14'h0
            |=> gap_active && gap_cnt == $past(min_entry_request_gap);
    endproperty
    a_nak_starts: assert property (p_nak_starts) else $error("gap not started");

    property p_restart;
        @(posedge mclk) disable iff (rst)
        gap_active && req_dllp_rx && !gap_timer_start_select
            |=> gap_active && gap_cnt == $past(min_entry_request_gap);
    endproperty
    a_restart: assert property (p_restart) else $error("gap not restarted");

    property p_ignore;
        @(posedge mclk) disable iff (rst)
        gap_active && gap_timer_start_select && gap_cnt > 14'h1
            |=> gap_cnt == $past(gap_cnt) - 14'h1;
    endproperty
    a_ignore: assert property (p_ignore) else $error("gap count disturbed");

    property p_expire;
        @(posedge mclk) disable iff (rst)
        gap_active && gap_cnt == 14'h1 && !(req_dllp_rx && !gap_timer_start_select)
            |=> state == LART_IDLE;
    endproperty
    a_expire: assert property (p_expire) else $error("gap did not expire");

    property p_fresh;
        @(posedge mclk) disable iff (rst)
        new_request |=> request_open;
    endproperty
    a_fresh: assert property (p_fresh) else $error("fresh request lost");

    property p_close;
        @(posedge mclk) disable iff (rst)
        request_open && ack_tx && !nak_tx |=> state == LART_IDLE;
    endproperty
    a_close: assert property (p_close) else $error("ack did not close");

    property p_reserved;
        @(posedge mclk) disable iff (rst)
        1'b1 |-> reg_rdata[15:14] == 2'h0 && reg_rdata[31:17] == 15'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_reset_val;
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> min_entry_request_gap == LART_GAP_RST
            && gap_timer_start_select == LART_START_SEL_RST;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad gap reset");

    // zero gap: a reject closes the request with no hold-off
    property p_zero_gap;
        @(posedge mclk) disable iff (rst)
        request_open && nak_tx && min_entry_request_gap == 14'h0 |=> state == LART_IDLE;
    endproperty
    a_zero_gap: assert property (p_zero_gap) else $error("zero gap held off");

    property p_open_holds;
        @(posedge mclk) disable iff (rst)
        request_open && !ack_tx && !nak_tx |=> request_open;
    endproperty
    a_open_holds: assert property (p_open_holds) else $error("request closed early");

    property p_idle_stays;
        @(posedge mclk) disable iff (rst)
        state == LART_IDLE && !req_dllp_rx |=> state == LART_IDLE;
    endproperty
    a_idle_stays: assert property (p_idle_stays) else $error("left idle with no request");
endmodule

// File: hdl/lart_pkg.sv
// Purpose: constants for the l1 entry reject gap timer
// Assumes: one 10 MHz clock, plain register port
// Notes:   register offset is a byte address
package lart_pkg;
    localparam logic [11:0] LART_CTRL_OFS       = 12'h710;
    localparam int          LART_GAP_LSB        = 0;
    localparam int          LART_GAP_W          = 14;
    localparam int          LART_START_SEL_BIT  = 16;
    localparam logic [13:0] LART_GAP_RST        = 14'h0947;
    localparam logic        LART_START_SEL_RST  = 1'h1;
    localparam int          LART_UNIT_PS        = 4000;
    localparam int          LART_CLK_PS         = 100000;
    // one gap unit per mclk cycle; the tick is a unit of the gap count
    localparam int          LART_UNIT_CYC       = (LART_UNIT_PS + LART_CLK_PS - 1) / LART_CLK_PS;
    typedef enum logic [1:0] {LART_IDLE, LART_REQ, LART_GAP} lart_state_e;
endpackage

// File: tb/lart_partner.sv
// Purpose: link partner that sends l1 entry request dllps
// Assumes: one dllp per cycle that go is high
// Notes:   the bench closes every request but the last with ack or nak
`timescale 1ns/1ps
module lart_partner (
    // command from the bench
    input  wire logic go,
    // toward the port
    output logic      req_dllp_rx
);
    assign req_dllp_rx = go;
endmodule

// File: tb/testbench.sv
// Purpose: bench for the l1 entry reject gap timer
// Assumes: gap shortened to 3 through the register
// Notes:   link events are one-cycle pulses
`timescale 1ns/1ps
module testbench;
    import lart_pkg::*;
    logic        mclk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic        go = 1'h0, ack_tx = 1'h0, nak_tx = 1'h0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        req_dllp_rx, new_request, request_open, gap_active;
    int          fails = 0, compares = 0, n;
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
    always #50 mclk = ~mclk;
    lart_partner u_far (.go(go), .req_dllp_rx(req_dllp_rx));
    lart_gap_timer u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_dllp_rx(req_dllp_rx),
        .ack_tx(ack_tx), .nak_tx(nak_tx), .new_request(new_request),
        .request_open(request_open), .gap_active(gap_active));
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk) begin
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'h1;
        end
        @(posedge mclk) reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk) begin
            reg_addr <= a;
            reg_rd   <= 1'h1;
        end
        @(posedge mclk) reg_rd <= 1'h0;
        @(negedge mclk) `CHK("rdata", e, reg_rdata)
    endtask
    // k: 0 request dllp, 1 nak, 2 ack, 3 quiet cycle
    task automatic ev(input int k, input logic want);
        @(posedge mclk) begin
            go     <= (k == 0);
            nak_tx <= (k == 1);
            ack_tx <= (k == 2);
        end
        @(negedge mclk) if (k == 0) `CHK("new_request", want, new_request)
    endtask
    // n counts gap cycles after the first one, or after the first two when restart_req is set
    task automatic reject(input logic restart_req);
        ev(0, 1'h1);
        ev(1, 1'h0);
        `CHK("request_open", 1'h1, request_open)
        ev(3, 1'h0);
        if (restart_req)
            ev(0, 1'h0);
        n = 0;
        repeat (12) begin
            ev(3, 1'h0);
            n += gap_active;
        end
    endtask
    task automatic finish_test;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        rd(LART_CTRL_OFS, 32'h00010947);
        wr(LART_CTRL_OFS, 32'hfffec003);
        wr(12'h714, 32'h0000ffff);
        rd(LART_CTRL_OFS, 32'h00000003);
        rd(12'h714, 32'h00000000);
        reject(1'h0);
        `CHK("gap_len", 3, n + 1)
        reject(1'h1);
        `CHK("restart", 3, n)
        wr(LART_CTRL_OFS, 32'h00010003);
        reject(1'h1);
        `CHK("ignore", 1, n)
        ev(0, 1'h1);
        ev(2, 1'h0);
        ev(3, 1'h0);
        `CHK("gap_after_ack", 1'h0, gap_active)
        wr(LART_CTRL_OFS, 32'h00010000);
        ev(0, 1'h1);
        ev(0, 1'h0);
        ev(1, 1'h0);
        ev(3, 1'h0);
        `CHK("zero_gap", 1'h0, gap_active)
        `CHK("closed", 1'h0, request_open)
        ev(0, 1'h1);
        finish_test;
    end
    initial begin
        #100000;
        fails++;
        finish_test;
    end
endmodule
